/* logic/dbab_defines.svh */
// Register offsets, field positions, reset values and timing counts of the DMA arbitration bridge.
`ifndef DBAB_DEFINES_SVH
`define DBAB_DEFINES_SVH
`define DBAB_OFS_CTRL 8'h00
`define DBAB_OFS_STAT 8'h04
`define DBAB_OFS_UP0 8'h08
`define DBAB_OFS_UP1 8'h0c
`define DBAB_OFS_SSEL 8'h10
`define DBAB_CHAN_PAGE 3'h1
`define DBAB_IN_AS 0
`define DBAB_IN_DT 1
`define DBAB_IN_GNT 2
`define DBAB_IN_BGA 3
`define DBAB_IN_RW 4
`define DBAB_RST_UP 8'h00
`define DBAB_RST_SSEL 4'h0
`define DBAB_RST_CTRL 9'h000
`define DBAB_STB_NS 370
`define DBAB_CLK_NS 8
`define DBAB_STB_CYC ((`DBAB_STB_NS + `DBAB_CLK_NS - 1) / `DBAB_CLK_NS)
`endif

/* logic/dbab_pkg.sv */
// Types shared by the DMA arbitration bridge.
package dbab_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_OWN = 3'b001,
    S_STB = 3'b010,
    S_ACK = 3'b011,
    S_END = 3'b100
  } dbab_fsm_e;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } dbab_wb_req_s;

  typedef struct packed {
    logic [3:0] rq1;
    logic [3:0] rq2;
    logic [4:0] in1;
    logic [4:0] in2;
    logic wb_ack;
    logic [31:0] wb_dat;
    logic [3:0] burst;
    logic [3:0] m2p;
    logic seq;
    logic [7:0] up0;
    logic [7:0] up1;
    logic [3:0] ssel;
    logic [3:0][15:0] addr;
    logic [3:0][15:0] cnt;
    logic [3:0] done;
    dbab_fsm_e fsm;
    logic [1:0] ch;
    logic halt;
    logic own;
    logic stb_n;
    logic stb_prev;
    logic [5:0] tcnt;
    logic breq_n;
    logic nown;
    logic [23:1] o_addr;
    logic o_ubs_n;
    logic o_lbs_n;
    logic o_sys_rw;
    logic o_prw;
    logic o_ack_a;
  } dbab_st_s;
endpackage

/* logic/dbab_bridge.sv */
// DMA bus arbitration bridge: bus ownership handshake, byte sequencer and processor bus adapter.
//
// Our own choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
`include "dbab_defines.svh"

module dbab_bridge (
  // Clock, reset and freeze.
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  // Wishbone slave.
  input wire dbab_pkg::dbab_wb_req_s wb_req_in,
  output logic wb_ack_out,
  output logic [31:0] wb_dat_out,
  // Service requests.
  input wire logic rx_service_request_in,
  input wire logic tx_service_request_in,
  input wire logic [1:0] transfer_request_in,
  // Processor bus handshake.
  output logic bus_request_n_out,
  input wire logic bus_grant_n_in,
  input wire logic bus_grant_ack_n_in,
  output logic bus_grant_ack_n_out,
  output logic bus_grant_ack_oe_n_out,
  input wire logic address_strobe_n_in,
  output logic address_strobe_n_out,
  output logic address_strobe_oe_n_out,
  input wire logic transfer_ack_n_in,
  input wire logic sys_rw_in,
  // System address, strobes and direction.
  output logic [23:1] system_address_lines_out,
  output logic upper_byte_strobe_n_out,
  output logic lower_byte_strobe_n_out,
  output logic sys_rw_out,
  output logic sys_oe_n_out,
  // Controller and peripheral side.
  output logic halt_request_out,
  output logic dma_grant_out,
  output logic channel_ack_a_out,
  output logic periph_rw_out
);
  import dbab_pkg::*;

  dbab_st_s st_ff;
  dbab_st_s nxt_st;
  logic [3:0] req_pin;
  logic [3:0] pend;
  logic [1:0] pick;
  logic as_s;
  logic dt_s;
  logic bga_s;
  logic edge_s;
  logic wb_hit;
  logic [31:0] rd_val;
  logic [31:0] wr_val;
  logic [4:0] chan_sel;

  //////////////////////////////////////////////////////////////////////////////
  // Byte-lane merge for partial Wishbone writes.
  function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Receiver and transmitter service requests occupy channels 0 and 1.
  assign req_pin = {transfer_request_in, tx_service_request_in, rx_service_request_in};

  // Synchronised, active-high views of the handshake pins; only the second stage is read.
  assign as_s = ~st_ff.in2[`DBAB_IN_AS];
  assign dt_s = ~st_ff.in2[`DBAB_IN_DT];
  assign bga_s = ~st_ff.in2[`DBAB_IN_BGA];

  // Strobe rise seen one cycle late, so ownership never drops mid-strobe.
  assign edge_s = st_ff.stb_n & ~st_ff.stb_prev;

  // Channels with a request and bytes left; lowest index wins.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pend[i] = st_ff.rq2[i] & (st_ff.cnt[i] != 16'h0000);
    end
  end

  always_comb begin
    if (pend[0]) begin
      pick = 2'h0;
    end else if (pend[1]) begin
      pick = 2'h1;
    end else if (pend[2]) begin
      pick = 2'h2;
    end else begin
      pick = 2'h3;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register read view; reused as the base of a partial write.
  assign wb_hit = wb_req_in.cyc & wb_req_in.stb & ~st_ff.wb_ack;
  assign chan_sel = wb_req_in.adr[7:3];

  always_comb begin
    rd_val = 32'h0000_0000;
    if (wb_req_in.adr[7:5] == `DBAB_CHAN_PAGE) begin
      if (wb_req_in.adr[2]) begin
        rd_val = {16'h0000, st_ff.cnt[chan_sel[1:0]]};
      end else begin
        rd_val = {16'h0000, st_ff.addr[chan_sel[1:0]]};
      end
    end else begin
      case (wb_req_in.adr)
        `DBAB_OFS_CTRL: rd_val = {23'h000000, st_ff.seq, st_ff.m2p, st_ff.burst};
        `DBAB_OFS_STAT: rd_val = {20'h00000, ~st_ff.in2[`DBAB_IN_GNT], st_ff.fsm, st_ff.ch,
                                  st_ff.own, st_ff.halt, st_ff.done};
        `DBAB_OFS_UP0: rd_val = {24'h000000, st_ff.up0};
        `DBAB_OFS_UP1: rd_val = {24'h000000, st_ff.up1};
        `DBAB_OFS_SSEL: rd_val = {28'h0000000, st_ff.ssel};
        default: rd_val = 32'h0000_0000;
      endcase
    end
  end

  assign wr_val = wb_merge(rd_val, wb_req_in.dat, wb_req_in.sel);

  //////////////////////////////////////////////////////////////////////////////
  // Next state: synchronisers, bus slave, sequencer, ownership and pin drive.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rq1 = req_pin;
    nxt_st.rq2 = st_ff.rq1;
    nxt_st.in1 = {sys_rw_in, bus_grant_ack_n_in, bus_grant_n_in, transfer_ack_n_in,
                  address_strobe_n_in};
    nxt_st.in2 = st_ff.in1;
    nxt_st.stb_prev = st_ff.stb_n;

    // Every access answers next cycle; unmapped reads give zero and writes vanish.
    nxt_st.wb_ack = wb_hit;
    nxt_st.wb_dat = 32'h0000_0000;
    if (wb_hit && !wb_req_in.we) begin
      nxt_st.wb_dat = rd_val;
    end
    if (wb_hit && wb_req_in.we) begin
      if (wb_req_in.adr[7:5] == `DBAB_CHAN_PAGE) begin
        if (wb_req_in.adr[2]) begin
          nxt_st.cnt[chan_sel[1:0]] = wr_val[15:0];
        end else begin
          nxt_st.addr[chan_sel[1:0]] = wr_val[15:0];
        end
      end else begin
        case (wb_req_in.adr)
          `DBAB_OFS_CTRL: begin
            nxt_st.burst = wr_val[3:0];
            nxt_st.m2p = wr_val[7:4];
            nxt_st.seq = wr_val[8];
          end
          `DBAB_OFS_STAT: nxt_st.done = st_ff.done & ~wr_val[3:0];
          `DBAB_OFS_UP0: nxt_st.up0 = wr_val[7:0];
          `DBAB_OFS_UP1: nxt_st.up1 = wr_val[7:0];
          `DBAB_OFS_SSEL: nxt_st.ssel = wr_val[3:0];
          default: nxt_st.done = st_ff.done;
        endcase
      end
    end

    // Ownership once halt is up and the bus is quiet.
    if (st_ff.halt && !st_ff.own && !as_s && !dt_s && !bga_s) begin
      nxt_st.own = 1'b1;
    end

    // Halt-only sequencer; there is no three-state steal path by design.
    case (st_ff.fsm)
      S_IDLE: begin
        if (pend != 4'h0) begin
          nxt_st.ch = pick;
          nxt_st.halt = 1'b1;
          nxt_st.fsm = S_OWN;
        end
      end
      S_OWN: begin
        // A leftover acknowledge from the previous byte must clear first.
        if (st_ff.own && st_ff.halt && st_ff.rq2[st_ff.ch] && !dt_s) begin
          nxt_st.stb_n = 1'b0;
          nxt_st.tcnt = 6'(`DBAB_STB_CYC - 1);
          nxt_st.fsm = S_STB;
        end
      end
      S_STB: begin
        if (st_ff.tcnt == 6'h00) begin
          nxt_st.fsm = S_ACK;
        end else begin
          nxt_st.tcnt = st_ff.tcnt - 6'h01;
        end
      end
      S_ACK: begin
        // Slow memories stretch the strobe beyond its minimum.
        if (dt_s) begin
          nxt_st.stb_n = 1'b1;
          nxt_st.addr[st_ff.ch] = st_ff.addr[st_ff.ch] + 16'h0001;
          nxt_st.cnt[st_ff.ch] = st_ff.cnt[st_ff.ch] - 16'h0001;
          nxt_st.fsm = S_END;
        end
      end
      S_END: begin
        if (edge_s) begin
          if (!st_ff.burst[st_ff.ch] || st_ff.cnt[st_ff.ch] == 16'h0000) begin
            nxt_st.own = 1'b0;
            nxt_st.halt = 1'b0;
            nxt_st.fsm = S_IDLE;
          end else begin
            nxt_st.fsm = S_OWN;
          end
          // Completion is applied after the clear so it is never lost.
          if (st_ff.cnt[st_ff.ch] == 16'h0000) begin
            nxt_st.done[st_ff.ch] = 1'b1;
          end
        end
      end
      default: begin
        nxt_st.fsm = S_IDLE;
        nxt_st.stb_n = 1'b1;
      end
    endcase

    // Bus request tracks requests so arbitration overlaps the halt.
    nxt_st.breq_n = ~(|st_ff.rq2);
    nxt_st.nown = ~nxt_st.own;

    // Channel 1 alone raises acknowledge A; others use the channel 0 latch.
    nxt_st.o_ack_a = (nxt_st.ch == 2'h1);

    // Upper latch plus controller address span the full 24-bit space.
    if (nxt_st.seq) begin
      nxt_st.o_addr = {(nxt_st.o_ack_a ? nxt_st.up1 : nxt_st.up0),
                       nxt_st.addr[nxt_st.ch][15:1]};
      nxt_st.o_ubs_n = nxt_st.addr[nxt_st.ch][0];
      nxt_st.o_lbs_n = ~nxt_st.addr[nxt_st.ch][0];
    end else begin
      nxt_st.o_addr = {(nxt_st.o_ack_a ? nxt_st.up1[6:0] : nxt_st.up0[6:0]),
                       nxt_st.addr[nxt_st.ch]};
      nxt_st.o_ubs_n = nxt_st.o_ack_a ? nxt_st.ssel[3] : nxt_st.ssel[1];
      nxt_st.o_lbs_n = nxt_st.o_ack_a ? nxt_st.ssel[2] : nxt_st.ssel[0];
    end

    // Memory direction per channel; peripheral sees the opposite while granted.
    nxt_st.o_sys_rw = nxt_st.m2p[nxt_st.ch];
    nxt_st.o_prw = nxt_st.own ? ~nxt_st.o_sys_rw : st_ff.in2[`DBAB_IN_RW];
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register; a low clock enable freezes everything.
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_ff <= '0;
      st_ff.in1 <= 5'h1f;
      st_ff.in2 <= 5'h1f;
      st_ff.up0 <= `DBAB_RST_UP;
      st_ff.up1 <= `DBAB_RST_UP;
      st_ff.ssel <= `DBAB_RST_SSEL;
      {st_ff.seq, st_ff.m2p, st_ff.burst} <= `DBAB_RST_CTRL;
      st_ff.fsm <= S_IDLE;
      st_ff.stb_n <= 1'b1;
      st_ff.stb_prev <= 1'b1;
      st_ff.breq_n <= 1'b1;
      st_ff.nown <= 1'b1;
      st_ff.o_ubs_n <= 1'b1;
      st_ff.o_lbs_n <= 1'b1;
      st_ff.o_sys_rw <= 1'b1;
      st_ff.o_prw <= 1'b1;
    end else if (ce_in) begin
      st_ff <= nxt_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs, each taken straight from the state register.
  assign wb_ack_out = st_ff.wb_ack;
  assign wb_dat_out = st_ff.wb_dat;
  assign bus_request_n_out = st_ff.breq_n;
  assign bus_grant_ack_n_out = st_ff.nown;
  assign bus_grant_ack_oe_n_out = st_ff.nown;
  assign address_strobe_n_out = st_ff.stb_n;
  assign address_strobe_oe_n_out = st_ff.nown;
  assign system_address_lines_out = st_ff.o_addr;
  assign upper_byte_strobe_n_out = st_ff.o_ubs_n;
  assign lower_byte_strobe_n_out = st_ff.o_lbs_n;
  assign sys_rw_out = st_ff.o_sys_rw;
  assign sys_oe_n_out = st_ff.nown;
  assign halt_request_out = st_ff.halt;
  assign dma_grant_out = st_ff.own;
  assign channel_ack_a_out = st_ff.o_ack_a;
  assign periph_rw_out = st_ff.o_prw;

  //////////////////////////////////////////////////////////////////////////////
  // Checks on the arbitration and adapter behaviour.
  AST_IDLE_QUIET: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    (st_ff.fsm == S_IDLE && !st_ff.halt) |-> (!st_ff.own && st_ff.stb_n && st_ff.nown))
    else $error("idle bridge holds grant or strobe");

  AST_BREQ_FOLLOWS: assert property (@(posedge mclk_in) disable iff (!arst_n_in || !ce_in)
    (|st_ff.rq2) |=> !st_ff.breq_n)
    else $error("bus request missing while a request is active");

  AST_OWN_SET: assert property (@(posedge mclk_in) disable iff (!arst_n_in || !ce_in)
    (st_ff.halt && !st_ff.own && !as_s && !dt_s && !bga_s) |=> (st_ff.own && !st_ff.nown))
    else $error("ownership not taken on a quiet bus");

  AST_SINGLE_DROP: assert property (@(posedge mclk_in) disable iff (!arst_n_in || !ce_in)
    (st_ff.fsm == S_END && edge_s && !st_ff.burst[st_ff.ch]) |=> (!st_ff.own ##1 st_ff.nown))
    else $error("single mode kept the bus after a byte");

  AST_BURST_HOLD: assert property (@(posedge mclk_in) disable iff (!arst_n_in || !ce_in)
    (st_ff.fsm == S_END && edge_s && st_ff.burst[st_ff.ch] && st_ff.cnt[st_ff.ch] != 16'h0000)
    |=> (st_ff.own && st_ff.halt))
    else $error("burst mode released the bus early");

  // The strobe rise is seen while halt still stands; the registered edge drops it one cycle later.
  // Checking a cycle later would miss the drop, since the next request may raise halt again.
  AST_HALT_AFTER_BYTE: assert property (@(posedge mclk_in) disable iff (!arst_n_in || !ce_in)
    ($rose(st_ff.stb_n) && !st_ff.burst[st_ff.ch]) |-> (st_ff.halt ##1 !st_ff.halt))
    else $error("halt not dropped after a single byte");

  AST_STROBE_MIN: assert property (@(posedge mclk_in) disable iff (!arst_n_in || !ce_in)
    $fell(st_ff.stb_n) |-> ##46 !st_ff.stb_n)
    else $error("address strobe shorter than its minimum");

  AST_STROBE_GATED: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    $fell(st_ff.stb_n) |-> ($past(st_ff.own) && st_ff.halt && $past(st_ff.rq2[st_ff.ch])))
    else $error("transfer started without grant, halt and request");

  AST_RW_INVERT: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    !st_ff.nown |-> (st_ff.o_prw != st_ff.o_sys_rw))
    else $error("peripheral direction not inverted under grant");

  AST_SEQ_ONE_STROBE: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    (!st_ff.nown && st_ff.seq) |-> (st_ff.o_ubs_n != st_ff.o_lbs_n))
    else $error("sequential variant drives both or no strobes");

  AST_LATCH_SELECT: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    (!st_ff.nown && !st_ff.seq) |-> (st_ff.o_addr[23:17] == (st_ff.o_ack_a ? st_ff.up1[6:0] : st_ff.up0[6:0])))
    else $error("upper address taken from the wrong latch");
endmodule

/* sim/dbab_bus_model.sv */
// Behavioural processor and memory that sit on the far side of the DMA bridge.
`timescale 1ns/1ps
module dbab_bus_model (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // Bench controls.
  input wire logic proc_busy_in,
  input wire logic [7:0] ack_dly_in,
  // Bridge drive.
  input wire logic bus_request_n_in,
  input wire logic gack_n_in,
  input wire logic gack_oe_n_in,
  input wire logic as_n_in,
  input wire logic as_oe_n_in,
  // Resolved lines.
  output logic bus_grant_n_out,
  output logic gack_wire_n_out,
  output logic as_wire_n_out,
  output logic mem_ack_n_out
);
  logic [7:0] wait_ff;
  ////////////////////////////////////////////////////////////////////////////////
  // Pull-ups return both shared lines high once every driver lets go.
  assign gack_wire_n_out = (!gack_oe_n_in && !gack_n_in) ? 1'b0 : 1'b1;
  // A busy processor cycle keeps the strobe low, so the bridge must wait.
  assign as_wire_n_out = (proc_busy_in || (!as_oe_n_in && !as_n_in)) ? 1'b0 : 1'b1;
  // Grant only between own cycles; withdrawn once the acknowledge appears.
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bus_grant_n_out <= 1'b1;
    end else begin
      bus_grant_n_out <= !(!bus_request_n_in && gack_wire_n_out && !proc_busy_in);
    end
  end
  // Memory answers a strobe after a set wait and lets go as soon as the strobe ends.
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wait_ff <= 8'h00;
      mem_ack_n_out <= 1'b1;
    end else if (as_wire_n_out) begin
      wait_ff <= 8'h00;
      mem_ack_n_out <= 1'b1;
    end else if (wait_ff == ack_dly_in) begin
      mem_ack_n_out <= 1'b0;
    end else begin
      wait_ff <= wait_ff + 8'h01;
    end
  end
endmodule

/* sim/tb.sv */
// Self-checking bench for the DMA bus arbitration bridge.
`timescale 1ns/1ps
module tb;
  import dbab_pkg::*;
  logic mclk, arst_n, ce, rx_req, tx_req, sys_rw, busy, wb_ack, bus_req_n, gnt_n, bga_n, bga_oe_n, bga_w;
  logic as_n, as_oe_n, as_w, mack_n, ubs_n, lbs_n, s_rw, s_oe_n, halt, grant, ack_a, prw;
  logic [1:0] trq;
  logic [7:0] dly;
  logic [31:0] wb_dat, v;
  logic [23:1] sa;
  logic [15:0] a;
  dbab_wb_req_s wb_req;
  int num_errors, checked;
  ////////////////////////////////////////////////////////////////////////////////
  dbab_bridge i_dbab_bridge (.mclk_in(mclk), .arst_n_in(arst_n), .ce_in(ce), .wb_req_in(wb_req),
    .wb_ack_out(wb_ack), .wb_dat_out(wb_dat), .rx_service_request_in(rx_req),
    .tx_service_request_in(tx_req), .transfer_request_in(trq), .bus_request_n_out(bus_req_n),
    .bus_grant_n_in(gnt_n), .bus_grant_ack_n_in(bga_w), .bus_grant_ack_n_out(bga_n),
    .bus_grant_ack_oe_n_out(bga_oe_n), .address_strobe_n_in(as_w), .address_strobe_n_out(as_n),
    .address_strobe_oe_n_out(as_oe_n), .transfer_ack_n_in(mack_n), .sys_rw_in(sys_rw),
    .system_address_lines_out(sa), .upper_byte_strobe_n_out(ubs_n), .lower_byte_strobe_n_out(lbs_n),
    .sys_rw_out(s_rw), .sys_oe_n_out(s_oe_n), .halt_request_out(halt), .dma_grant_out(grant),
    .channel_ack_a_out(ack_a), .periph_rw_out(prw));
  dbab_bus_model i_dbab_bus_model (.mclk_in(mclk), .arst_n_in(arst_n), .proc_busy_in(busy),
    .ack_dly_in(dly), .bus_request_n_in(bus_req_n), .gack_n_in(bga_n), .gack_oe_n_in(bga_oe_n),
    .as_n_in(as_n), .as_oe_n_in(as_oe_n), .bus_grant_n_out(gnt_n), .gack_wire_n_out(bga_w),
    .as_wire_n_out(as_w), .mem_ack_n_out(mack_n));
  ////////////////////////////////////////////////////////////////////////////////
  // Compare one value and count it.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One classic cycle; the request holds until ack is sampled high at an edge.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: dat};
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1);
    v = wb_dat;
    wb_req <= '0;
    @(posedge mclk);
  endtask
  // Follow one byte: ownership, what the bridge drives, strobe length, release.
  task automatic xfer(input logic [23:1] ea, input logic [1:0] es, input logic e1, input logic erw,
                      input logic mid);
    int n;
    logic rel;
    n = 0;
    rel = 1'b0;
    while ((grant !== 1'b1 || as_w !== 1'b0) && n < 500) begin
      @(posedge mclk);
      n++;
    end
    chk(n < 500, 1'b1);
    chk({halt, bus_req_n, bga_n, bga_oe_n, as_oe_n, s_oe_n}, 6'h20);
    chk(sa, ea);
    chk({ubs_n, lbs_n}, es);
    chk(ack_a, e1);
    chk({s_rw, prw}, {erw, !erw});
    n = 0;
    while (as_w === 1'b0 && n < 500) begin
      @(posedge mclk);
      n++;
    end
    chk(n >= 47 && n < 500, 1'b1);
    repeat (4) begin
      @(posedge mclk);
      if (grant === 1'b0 && halt === 1'b0) rel = 1'b1;
    end
    chk(rel, !mid);
  endtask
  // Print the counts and the verdict, then stop.
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Free-running 125 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // The whole run needs several hundred cycles; a hang is cut off well beyond that.
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    complete_run();
  end
  // Main sequence.
  initial begin
    arst_n = 1'b0;
    wb_req = '0;
    rx_req = 1'b0;
    ce = 1'b1;
    trq = 2'b00;
    tx_req = 1'b0;
    sys_rw = 1'b1;
    busy = 1'b0;
    dly = 8'h02;
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    chk({grant, bga_oe_n, as_w, halt, bus_req_n}, 5'b01101);
    wb(1'b1, 8'h08, 32'h55);
    wb(1'b1, 8'h0c, 32'h2a);
    wb(1'b1, 8'h10, 32'h1);
    wb(1'b0, 8'h10, 32'h0);
    chk(v, 32'h1);
    wb(1'b0, 8'h0c, 32'h0);
    chk(v, 32'h2a);
    wb(1'b0, 8'h1c, 32'h0);
    chk(v, 32'h0);
    sys_rw <= 1'b0;
    repeat (4) @(posedge mclk);
    chk(prw, 1'b0);
    sys_rw <= 1'b1;
    // Single bytes on channel 0 while the processor still holds the bus.
    wb(1'b1, 8'h20, 32'h1234);
    wb(1'b1, 8'h24, 32'h2);
    wb(1'b1, 8'h00, 32'h0);
    busy <= 1'b1;
    rx_req <= 1'b1;
    repeat (20) @(posedge mclk);
    chk({halt, grant, bus_req_n}, 3'b100);
    busy <= 1'b0;
    xfer({7'h55, 16'h1234}, 2'b01, 1'b0, 1'b0, 1'b0);
    xfer({7'h55, 16'h1235}, 2'b01, 1'b0, 1'b0, 1'b0);
    repeat (10) @(posedge mclk);
    chk({halt, grant}, 2'b00);
    wb(1'b0, 8'h04, 32'h0);
    chk(v[0], 1'b1);
    chk(v[11], 1'b1);
    rx_req <= 1'b0;
    repeat (5) @(posedge mclk);
    chk(bus_req_n, 1'b1);
    // Burst of three words on channel 1 against slow memory.
    dly <= 8'h3c;
    wb(1'b1, 8'h28, 32'h8000);
    wb(1'b1, 8'h2c, 32'h3);
    wb(1'b1, 8'h00, 32'h22);
    tx_req <= 1'b1;
    for (a = 16'h8000; a < 16'h8003; a++) begin
      xfer({7'h2a, a}, 2'b00, 1'b1, 1'b1, a != 16'h8002);
    end
    tx_req <= 1'b0;
    // Sequential bytes: strobes alternate on address bit 0.
    dly <= 8'h02;
    wb(1'b1, 8'h08, 32'h81);
    wb(1'b1, 8'h20, 32'h10);
    wb(1'b1, 8'h24, 32'h2);
    wb(1'b1, 8'h00, 32'h100);
    // A low clock enable freezes the request synchronisers, so nothing starts.
    ce <= 1'b0;
    rx_req <= 1'b1;
    repeat (10) @(posedge mclk);
    chk({halt, bus_req_n}, 2'b01);
    ce <= 1'b1;
    xfer({8'h81, 15'h0008}, 2'b01, 1'b0, 1'b0, 1'b0);
    xfer({8'h81, 15'h0008}, 2'b10, 1'b0, 1'b0, 1'b0);
    rx_req <= 1'b0;
    // Channel 2 shares the channel 0 latch; in sequential mode its strobes follow address bit 0.
    wb(1'b1, 8'h30, 32'h40);
    wb(1'b1, 8'h34, 32'h1);
    trq <= 2'b01;
    xfer({8'h81, 15'h0020}, 2'b01, 1'b0, 1'b0, 1'b0);
    trq <= 2'b00;
    repeat (5) @(posedge mclk);
    complete_run();
  end
endmodule
